// file: hw/eie_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "eie_params.svh"

module eie_irq_ctrl (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic [7:0] port_pins,
  input  wire logic       timer_five_low_overflow_flag,
  input  wire logic       timer_five_high_overflow_flag,
  input  wire logic       timer_four_low_overflow_flag,
  input  wire logic       timer_four_high_overflow_flag,
  input  wire logic       second_smbus_irq,
  input  wire logic       second_uart_irq,
  input  wire logic       usb_supply_sense_irq,
  input  wire logic       ext_zero_enable,
  input  wire logic       ext_one_enable,
  input  wire logic       ext_zero_vector_ack,
  input  wire logic       ext_one_vector_ack,
  output logic            timer_five_irq_req,
  output logic            timer_four_irq_req,
  output logic            second_smbus_irq_req,
  output logic            second_uart_irq_req,
  output logic            usb_supply_sense_irq_req,
  output logic            ext_zero_irq_req,
  output logic            ext_one_irq_req
);

  eie_pkg::eie_top_state_t state_reg;
  eie_pkg::eie_top_state_t state_next;

  eie_chan_if ch_zero ();
  eie_chan_if ch_one ();

  logic       hit_enable_two;
  logic       hit_timer_ctrl;
  logic       hit_pin_config;
  logic [7:0] read_value;
  logic       wr_enable_two;
  logic       wr_timer_ctrl;
  logic       wr_pin_config;
  logic [7:0] pins_synced;
  logic [7:0] timer_ctrl_read;
  logic       timer_five_overflow;
  logic       timer_four_overflow;

  logic timer_five_irq_enable;
  logic timer_four_irq_enable;
  logic second_smbus_irq_enable;
  logic second_uart_irq_enable;
  logic usb_supply_sense_irq_enable;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // One enable bit passes or masks one request line.
  function automatic logic gate_req(input logic enable, input logic request);
    gate_req = enable && request;
  endfunction : gate_req

  // Timer control as software sees it; the timer's own bits live elsewhere and read zero.
  function automatic logic [7:0] timer_ctrl_view(input logic zero_trig, input logic zero_pend,
                                                 input logic one_trig, input logic one_pend);
    timer_ctrl_view                        = 8'h00;
    timer_ctrl_view[`EIE_BIT_ZERO_TRIGGER] = zero_trig;
    timer_ctrl_view[`EIE_BIT_ZERO_PENDING] = zero_pend;
    timer_ctrl_view[`EIE_BIT_ONE_TRIGGER]  = one_trig;
    timer_ctrl_view[`EIE_BIT_ONE_PENDING]  = one_pend;
  endfunction : timer_ctrl_view

  // No page qualifier: the decode holds on every register page.
  assign hit_enable_two = addr_hit(sfr_addr, `EIE_ADDR_ENABLE_TWO);
  assign hit_timer_ctrl = addr_hit(sfr_addr, `EIE_ADDR_TIMER_CTRL);
  assign hit_pin_config = addr_hit(sfr_addr, `EIE_ADDR_PIN_CONFIG);

  assign wr_enable_two = sfr_wr && hit_enable_two;
  assign wr_timer_ctrl = sfr_wr && hit_timer_ctrl;
  assign wr_pin_config = sfr_wr && hit_pin_config;

  // All eight pins pass two flops ahead of the select mux, so a select change never
  // catches a pin in mid-transition and metastability stays out of the edge compare.
  assign pins_synced = state_reg.pin_sync;

  // One enable bit per peripheral request; bits 7:6 are never stored.
  assign timer_five_irq_enable       = state_reg.enable_two[`EIE_BIT_TIMER_FIVE];
  assign timer_four_irq_enable       = state_reg.enable_two[`EIE_BIT_TIMER_FOUR];
  assign second_smbus_irq_enable     = state_reg.enable_two[`EIE_BIT_SMBUS_TWO];
  assign second_uart_irq_enable      = state_reg.enable_two[`EIE_BIT_UART_TWO];
  assign usb_supply_sense_irq_enable = state_reg.enable_two[`EIE_BIT_USB_SENSE];

  // Each external channel has its own select, polarity and trigger type.
  assign ch_zero.pin_sel    = state_reg.pin_config[`EIE_FLD_ZERO_SEL_LSB +: `EIE_SEL_WIDTH];
  assign ch_zero.polarity   = state_reg.pin_config[`EIE_FLD_ZERO_POL];
  assign ch_zero.edge_mode  = state_reg.zero_trigger;
  assign ch_zero.vector_ack = ext_zero_vector_ack;
  // Each timer control write rewrites both pending bits; edge mode alone honours it.
  assign ch_zero.sw_write   = wr_timer_ctrl;
  assign ch_zero.sw_value   = sfr_wdata[`EIE_BIT_ZERO_PENDING];

  assign ch_one.pin_sel     = state_reg.pin_config[`EIE_FLD_ONE_SEL_LSB +: `EIE_SEL_WIDTH];
  assign ch_one.polarity    = state_reg.pin_config[`EIE_FLD_ONE_POL];
  assign ch_one.edge_mode   = state_reg.one_trigger;
  assign ch_one.vector_ack  = ext_one_vector_ack;
  assign ch_one.sw_write    = wr_timer_ctrl;
  assign ch_one.sw_value    = sfr_wdata[`EIE_BIT_ONE_PENDING];

  // Both channels watch the same synchronised port; each picks its own pin.
  eie_ext_chan u_chan_zero (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .port_pins (pins_synced),
    .ch        (ch_zero.chan)
  );

  eie_ext_chan u_chan_one (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .port_pins (pins_synced),
    .ch        (ch_one.chan)
  );

  assign timer_ctrl_read = timer_ctrl_view(state_reg.zero_trigger, ch_zero.pending,
                                           state_reg.one_trigger, ch_one.pending);

  // Read data; unmapped addresses read as zero.
  always_comb begin
    read_value = 8'h00;
    if (hit_enable_two) begin
      read_value = state_reg.enable_two & `EIE_ENABLE_TWO_WMASK;
    end else if (hit_timer_ctrl) begin
      read_value = timer_ctrl_read;
    end else if (hit_pin_config) begin
      read_value = state_reg.pin_config;
    end
  end

  always_comb begin
    state_next          = state_reg;
    state_next.pin_meta = port_pins;
    state_next.pin_sync = state_reg.pin_meta;
    // Reserved bit 2 is stored and read back but gates nothing.
    if (wr_enable_two) begin
      state_next.enable_two = sfr_wdata & `EIE_ENABLE_TWO_WMASK;
    end
    if (wr_timer_ctrl) begin
      state_next.zero_trigger = sfr_wdata[`EIE_BIT_ZERO_TRIGGER];
      state_next.one_trigger  = sfr_wdata[`EIE_BIT_ONE_TRIGGER];
    end
    if (wr_pin_config) begin
      state_next.pin_config = sfr_wdata;
    end
    if (sfr_rd) begin
      state_next.rdata = read_value;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.enable_two   <= `EIE_RST_ENABLE_TWO;
      state_reg.zero_trigger <= 1'b0;
      state_reg.one_trigger  <= 1'b0;
      state_reg.pin_config   <= `EIE_RST_PIN_CONFIG;
      state_reg.rdata        <= 8'h00;
      // Reset leaves both channels in level mode, so low synchronisers raise no false edge.
      state_reg.pin_meta     <= 8'h00;
      state_reg.pin_sync     <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata = state_reg.rdata;

  assign timer_five_overflow = timer_five_low_overflow_flag || timer_five_high_overflow_flag;
  assign timer_four_overflow = timer_four_low_overflow_flag || timer_four_high_overflow_flag;

  // Peripheral requests stay combinational so a flag reaches the CPU in the cycle it rises.
  assign timer_five_irq_req       = gate_req(timer_five_irq_enable,
                                             timer_five_overflow);
  assign timer_four_irq_req       = gate_req(timer_four_irq_enable,
                                             timer_four_overflow);
  assign second_smbus_irq_req     = gate_req(second_smbus_irq_enable,
                                             second_smbus_irq);
  assign second_uart_irq_req      = gate_req(second_uart_irq_enable,
                                             second_uart_irq);
  assign usb_supply_sense_irq_req = gate_req(usb_supply_sense_irq_enable,
                                             usb_supply_sense_irq);
  // A level source still active after service simply raises the request again.
  assign ext_zero_irq_req         = gate_req(ext_zero_enable,
                                             ch_zero.pending);
  assign ext_one_irq_req          = gate_req(ext_one_enable,
                                             ch_one.pending);

endmodule : eie_irq_ctrl

`default_nettype wire

// file: hw/eie_params.svh
`ifndef EIE_PARAMS_SVH
`define EIE_PARAMS_SVH

// Special-function addresses decoded by this block.
`define EIE_ADDR_ENABLE_TWO   8'he7
`define EIE_ADDR_TIMER_CTRL   8'h88
`define EIE_ADDR_PIN_CONFIG   8'he4

// Reset values.
`define EIE_RST_ENABLE_TWO    8'h00
`define EIE_RST_TIMER_CTRL    8'h00
`define EIE_RST_PIN_CONFIG    8'h00

// Writable bits of the second extended enable register.
`define EIE_ENABLE_TWO_WMASK  8'h3f

// Enable bit positions.
`define EIE_BIT_TIMER_FIVE    5
`define EIE_BIT_TIMER_FOUR    4
`define EIE_BIT_SMBUS_TWO     3
`define EIE_BIT_UART_TWO      1
`define EIE_BIT_USB_SENSE     0

// Timer control register bit positions.
`define EIE_BIT_ZERO_TRIGGER  0
`define EIE_BIT_ZERO_PENDING  1
`define EIE_BIT_ONE_TRIGGER   2
`define EIE_BIT_ONE_PENDING   3

// Pin configuration register fields.
`define EIE_FLD_ZERO_SEL_LSB  0
`define EIE_FLD_ZERO_POL      3
`define EIE_FLD_ONE_SEL_LSB   4
`define EIE_FLD_ONE_POL       7
`define EIE_SEL_WIDTH         3

`endif

// file: hw/eie_pkg.sv
package eie_pkg;

  typedef struct packed {
    logic [7:0] enable_two;
    logic       zero_trigger;
    logic       one_trigger;
    logic [7:0] pin_config;
    logic [7:0] rdata;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
  } eie_top_state_t;

  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic active_prev;
    logic pending;
  } eie_chan_state_t;

endpackage : eie_pkg

// file: hw/eie_chan_if.sv
`timescale 1ns/1ps
`default_nettype none

interface eie_chan_if;
  logic [2:0] pin_sel;
  logic       polarity;
  logic       edge_mode;
  logic       vector_ack;
  logic       sw_write;
  logic       sw_value;
  logic       pending;

  modport ctrl (output pin_sel, output polarity, output edge_mode, output vector_ack,
                output sw_write, output sw_value, input pending);
  modport chan (input pin_sel, input polarity, input edge_mode, input vector_ack,
                input sw_write, input sw_value, output pending);
endinterface : eie_chan_if

`default_nettype wire

// file: hw/eie_ext_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "eie_params.svh"

module eie_ext_chan (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] port_pins,
  eie_chan_if.chan        ch
);

  eie_pkg::eie_chan_state_t state_reg;
  eie_pkg::eie_chan_state_t state_next;

  logic active_now;

  // Polarity one means active high.
  assign active_now = ~(state_reg.sync_second ^ ch.polarity);
  assign ch.pending = state_reg.pending;

  always_comb begin
    state_next             = state_reg;
    // The pin is observed only; nothing here drives it.
    state_next.sync_first  = port_pins[ch.pin_sel];
    state_next.sync_second = state_reg.sync_first;
    state_next.active_prev = active_now;
    if (ch.edge_mode) begin
      if (ch.vector_ack) begin
        state_next.pending = 1'b0;
      end
      if (ch.sw_write) begin
        state_next.pending = ch.sw_value;
      end
      // A new edge wins over any clear in the same cycle.
      if (active_now && !state_reg.active_prev) begin
        state_next.pending = 1'b1;
      end
    end else begin
      state_next.pending = active_now;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : eie_ext_chan

`default_nettype wire

// file: tb/eie_irq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module eie_irq_checker (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       timer_five_low_overflow_flag,
  input wire logic       timer_five_high_overflow_flag,
  input wire logic       second_smbus_irq,
  input wire logic       second_uart_irq,
  input wire logic       ext_zero_enable,
  input wire logic       ext_one_enable,
  input wire logic       timer_five_irq_req,
  input wire logic       second_smbus_irq_req,
  input wire logic       second_uart_irq_req,
  input wire logic       ext_zero_irq_req,
  input wire logic       ext_one_irq_req
);
  logic [7:0] en_reg;
  logic       mapped;
  assign mapped = sfr_addr inside {8'he7, 8'h88, 8'he4};
  // Shadow of the enable register, rebuilt from bus writes alone.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) en_reg <= 8'h00;
    else if (sfr_wr && sfr_addr == 8'he7) en_reg <= sfr_wdata & 8'h3f;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_timer_five_gate: assert property (
    timer_five_irq_req == (en_reg[5] && (timer_five_low_overflow_flag ||
    timer_five_high_overflow_flag))) else $error("timer five request wrong");
  a_smbus_two_gate: assert property (
    second_smbus_irq_req == (en_reg[3] && second_smbus_irq)) else $error("smbus request wrong");
  a_uart_two_gate: assert property (
    second_uart_irq_req == (en_reg[1] && second_uart_irq)) else $error("uart request wrong");
  a_enable_read_back: assert property (
    sfr_rd && !sfr_wr && sfr_addr == 8'he7 |=> sfr_rdata == $past(en_reg))
    else $error("enable register read wrong");
  a_unmapped_read_zero: assert property (
    sfr_rd && !mapped |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (
    !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved without a read");
  a_ext_zero_masked: assert property (
    !ext_zero_enable |-> !ext_zero_irq_req) else $error("ext zero request while disabled");
  a_ext_one_masked: assert property (
    !ext_one_enable |-> !ext_one_irq_req) else $error("ext one request while disabled");
endmodule : eie_irq_checker
`default_nettype wire

// file: tb/eie_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
module eie_pin_src (
  input  wire logic [7:0] drive_level,
  output logic      [7:0] port_pins
);
  // Pins follow drive_level directly; only the test sequence decides when a level drops.
  assign port_pins = drive_level;
endmodule : eie_pin_src
`default_nettype wire

// file: tb/tb_eie_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_eie_irq_ctrl;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic [7:0] port_pins;
  logic [7:0] drive_level = 8'h20;
  logic [6:0] src = 7'h00;
  logic       ext_zero_enable = 1'b0;
  logic       ext_one_enable = 1'b0;
  logic       ext_zero_vector_ack = 1'b0;
  logic       ext_one_vector_ack = 1'b0;
  logic       timer_five_irq_req, timer_four_irq_req, second_smbus_irq_req;
  logic       second_uart_irq_req, usb_supply_sense_irq_req, ext_zero_irq_req, ext_one_irq_req;
  logic       rd_d = 1'b0;
  logic       snap = 1'b0;
  logic [7:0] req_vec;
  logic [7:0] exp_q[$];
  int         bad_count = 0;
  int         check_count = 0;
  int         cycles = 0;
  eie_irq_ctrl dut_u (.timer_five_low_overflow_flag(src[0]), .timer_five_high_overflow_flag(src[1]),
    .timer_four_low_overflow_flag(src[2]), .timer_four_high_overflow_flag(src[3]),
    .second_smbus_irq(src[4]), .second_uart_irq(src[5]), .usb_supply_sense_irq(src[6]), .*);
  eie_pin_src src_u (.drive_level(drive_level), .port_pins(port_pins));
  assign req_vec = {1'b0, ext_one_irq_req, ext_zero_irq_req, usb_supply_sense_irq_req,
    second_uart_irq_req, second_smbus_irq_req, timer_four_irq_req, timer_five_irq_req};
  initial forever #5 clk_sys = ~clk_sys;
  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
  endtask : rd
  task automatic req_chk(input logic [7:0] want);
    exp_q.push_back(want);
    @(posedge clk_sys);
    snap <= 1'b1;
    @(posedge clk_sys);
    snap <= 1'b0;
  endtask : req_chk
  always @(posedge clk_sys) begin
    rd_d <= sfr_rd;
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      give_verdict();
    end
  end
  // Results are taken at the falling edge, once the rising edge's updates have landed.
  always @(negedge clk_sys) begin
    if (rd_d === 1'b1) check(sfr_rdata, exp_q.pop_front());
    else if (snap === 1'b1) check(req_vec, exp_q.pop_front());
  end
  initial begin
    logic [7:0] en;
    logic [6:0] s;
    logic       trig;
    logic       pol;
    void'($urandom(32'h0befad67));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'he7, 8'h00);
    for (int i = 0; i < 12; i++) begin
      en = (i == 0) ? 8'hff : 8'($urandom);
      s = 7'($urandom);
      wr(8'he7, en);
      src <= s;
      rd(8'he7, en & 8'h3f);
      req_chk({3'b000, s[6] & en[0], s[5] & en[1], s[4] & en[3], (s[3] | s[2]) & en[4],
        (s[1] | s[0]) & en[5]});
    end
    rd(8'h12, 8'h00);
    wr(8'he7, 8'h00);
    ext_zero_enable <= 1'b1;
    ext_one_enable <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      trig = m[1];
      pol = m[0];
      drive_level <= {2'($urandom), 1'b1, 2'($urandom), ~pol, 2'($urandom)};
      repeat (6) @(posedge clk_sys);
      wr(8'he4, {4'h5, pol, 3'h2});
      repeat (6) @(posedge clk_sys);
      wr(8'h88, {7'h00, trig});
      repeat (6) @(posedge clk_sys);
      rd(8'h88, {7'h00, trig});
      drive_level[2] <= pol;
      repeat (6) @(posedge clk_sys);
      rd(8'h88, {6'h00, 1'b1, trig});
      req_chk(8'h20);
      drive_level[2] <= ~pol;
      repeat (6) @(posedge clk_sys);
      rd(8'h88, {6'h00, trig, trig});
      ext_zero_vector_ack <= 1'b1;
      @(posedge clk_sys);
      ext_zero_vector_ack <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rd(8'h88, {7'h00, trig});
    end
    drive_level[5] <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(8'h88, 8'h09);
    req_chk(8'h40);
    ext_one_vector_ack <= 1'b1;
    @(posedge clk_sys);
    ext_one_vector_ack <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(8'h88, 8'h09);
    drive_level[5] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(8'h88, 8'h01);
    wr(8'he4, 8'hda);
    drive_level[5] <= 1'b0;
    repeat (6) @(posedge clk_sys);
    wr(8'h88, 8'h05);
    repeat (6) @(posedge clk_sys);
    drive_level[5] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(8'h88, 8'h0d);
    req_chk(8'h40);
    ext_one_vector_ack <= 1'b1;
    @(posedge clk_sys);
    ext_one_vector_ack <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(8'h88, 8'h05);
    wr(8'h88, 8'h07);
    rd(8'h88, 8'h07);
    req_chk(8'h20);
    wr(8'h88, 8'h05);
    rd(8'h88, 8'h05);
    repeat (2) @(posedge clk_sys);
    give_verdict();
  end
endmodule : tb_eie_irq_ctrl
bind eie_irq_ctrl eie_irq_checker chk_u (.*);
`default_nettype wire
